// >>> charger_map.vh
`ifndef CHARGER_MAP_VH
`define CHARGER_MAP_VH

// register offsets
`define OFS_CHG_CTRL      8'h01
`define OFS_CHG_CURRENT   8'h02
`define OFS_PRE_TERM      8'h03
`define OFS_BAT_VOLTAGE   8'h04

// reset values
`define RST_CHG_CURRENT   8'h91
`define RST_PRE_TERM      8'h12
`define RST_BAT_VOLTAGE   8'h40
`define RST_CHARGE_ALLOW  1'h1

// field positions
`define BIT_SWITCH_FULL   6
`define BIT_WDOG_KICK     6
`define BIT_CHARGE_ALLOW  4
`define FLD_FAST_HI       5
`define FLD_PRE_HI        7
`define FLD_PRE_LO        4
`define FLD_TERM_HI       3
`define FLD_VOLT_HI       7
`define FLD_VOLT_LO       3
`define FLD_TOPOFF_HI     2
`define FLD_TOPOFF_LO     1
`define BIT_RECHARGE      0

// field decode constants
`define FAST_LINEAR_MAX   6'h3B
`define FAST_MA_3C        11'h50A
`define FAST_MA_3D        11'h550
`define FAST_MA_3E        11'h596
`define FAST_MA_3F        11'h5DC
`define STEP_CODE_MAX     4'hC
`define VOLT_LUT_MAX      5'h08
`define VOLT_LIN_BASE     13'h10CC
`define VOLT_LIN_FIRST    5'h09
`define TOPOFF_STEP_MIN   6'h0F
`define RECHG_LOW_MV      8'h78
`define RECHG_HIGH_MV     8'hD2
`define SWITCH_FULL_CAP   5'h06

// timing
`define CLK_HZ            40000000
`define WDOG_TIME_S       40
`define WDOG_CYCLES       (`WDOG_TIME_S * `CLK_HZ)

`endif

// >>> code_clamp.v
`timescale 1ns/10ps
`default_nettype none

module code_clamp #(
   parameter [3:0] MAX_CODE = 4'hC
) (
   input  wire [3:0] code_in,  // raw field code
   output wire [8:0] ma_out    // (code + 1) * 20 mA after clamp
);

   wire [3:0] lim_code;
   wire [4:0] steps;

   assign lim_code = (code_in > MAX_CODE) ? MAX_CODE : code_in;
   assign steps    = {1'b0, lim_code} + 5'h01;
   assign ma_out   = {steps, 4'h0} + {2'h0, steps, 2'h0};

endmodule // code_clamp

`default_nettype wire

// >>> i2c_target.v
`timescale 1ns/10ps
`default_nettype none

module i2c_target #(
   parameter [6:0] DEV_ADDR = 7'h2A
) (
   input  wire       clk_sys_in,   // system clock
   input  wire       reset_in,     // sync reset, active high
   input  wire       scl_in,       // serial clock pin
   input  wire       sda_in,       // serial data pin level
   output reg        sda_oe_out,   // pull data low while high
   output reg        wr_out,       // one-cycle register write strobe
   output reg  [7:0] ptr_out,      // register pointer
   output reg  [7:0] wdata_out,    // write data
   input  wire [7:0] rdata_in      // read data at ptr_out
);

   localparam [3:0] S_IDLE  = 4'h0;
   localparam [3:0] S_ADDR  = 4'h1;
   localparam [3:0] S_ACK_A = 4'h2;
   localparam [3:0] S_PTR   = 4'h3;
   localparam [3:0] S_ACK_P = 4'h4;
   localparam [3:0] S_WDATA = 4'h5;
   localparam [3:0] S_ACK_W = 4'h6;
   localparam [3:0] S_RDATA = 4'h7;
   localparam [3:0] S_ACK_R = 4'h8;

   reg [1:0] scl_sync_q;
   reg [1:0] sda_sync_q;
   reg       scl_p_q;
   reg       sda_p_q;
   reg [3:0] state_q;
   reg [3:0] cnt_q;
   reg [7:0] sr_q;
   reg [7:0] tx_q;
   reg       rw_q;
   reg       nack_q;

   wire scl_s = scl_sync_q[1];
   wire sda_s = sda_sync_q[1];
   wire rise  = scl_s & ~scl_p_q;
   wire fall  = ~scl_s & scl_p_q;
   wire start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire rx_st = (state_q == S_ADDR) | (state_q == S_PTR) |
                (state_q == S_WDATA);

   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
         state_q    <= S_IDLE;
         cnt_q      <= 4'h0;
         sr_q       <= 8'h00;
         tx_q       <= 8'h00;
         rw_q       <= 1'b0;
         nack_q     <= 1'b0;
         sda_oe_out <= 1'b0;
         wr_out     <= 1'b0;
         ptr_out    <= 8'h00;
         wdata_out  <= 8'h00;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         scl_p_q    <= scl_s;
         sda_p_q    <= sda_s;
         wr_out     <= 1'b0;
         if (stop) begin
            state_q    <= S_IDLE;
            sda_oe_out <= 1'b0;
         end else if (start) begin
            state_q    <= S_ADDR;
            cnt_q      <= 4'h0;
            sda_oe_out <= 1'b0;
         end else if (rise && rx_st) begin
            sr_q  <= {sr_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
         end else if (rise && state_q == S_ACK_R) begin
            nack_q <= sda_s;
         end else if (fall) begin
            case (state_q)
               S_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     if (sr_q[7:1] == DEV_ADDR) begin
                        rw_q       <= sr_q[0];
                        sda_oe_out <= 1'b1;
                        state_q    <= S_ACK_A;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_PTR: begin
                  if (cnt_q == 4'h8) begin
                     ptr_out    <= sr_q;
                     sda_oe_out <= 1'b1;
                     state_q    <= S_ACK_P;
                  end
               end
               S_WDATA: begin
                  if (cnt_q == 4'h8) begin
                     wdata_out  <= sr_q;
                     wr_out     <= 1'b1;
                     sda_oe_out <= 1'b1;
                     state_q    <= S_ACK_W;
                  end
               end
               S_ACK_A, S_ACK_P, S_ACK_W: begin
                  cnt_q <= 4'h0;
                  if (state_q == S_ACK_W) begin
                     ptr_out <= ptr_out + 8'h01;
                  end
                  if (state_q == S_ACK_A && rw_q) begin
                     tx_q       <= rdata_in;
                     sda_oe_out <= ~rdata_in[7];
                     state_q    <= S_RDATA;
                  end else begin
                     sda_oe_out <= 1'b0;
                     state_q    <= (state_q == S_ACK_A) ? S_PTR : S_WDATA;
                  end
               end
               S_RDATA: begin
                  if (cnt_q == 4'h7) begin
                     // release for the controller's acknowledge
                     sda_oe_out <= 1'b0;
                     ptr_out    <= ptr_out + 8'h01;
                     state_q    <= S_ACK_R;
                  end else begin
                     tx_q       <= {tx_q[6:0], 1'b0};
                     sda_oe_out <= ~tx_q[6];
                     cnt_q      <= cnt_q + 4'h1;
                  end
               end
               S_ACK_R: begin
                  cnt_q <= 4'h0;
                  if (nack_q) begin
                     state_q <= S_IDLE;
                  end else begin
                     tx_q       <= rdata_in;
                     sda_oe_out <= ~rdata_in[7];
                     state_q    <= S_RDATA;
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

endmodule // i2c_target

`default_nettype wire

// >>> charge_setpoint_registers.v
// How it works
// [RULE_01] 02h resets to 91h; reserved bit 7 powers up 1; all bits writable
// [RULE_02] 02h bits 5:0 fast charge current, 20 mA steps, default 340 mA
// [RULE_03] codes to 111011 linear up to 1180 mA; 111100 1290, 111101 1360 mA
// [RULE_04] codes 111110 and 111111 give 1430 mA and 1500 mA
// [RULE_05] a zero fast charge current disables charging
// [RULE_06] bit 6 at 02h forces full switch drive; above 700 mA always full
// [RULE_07] reset command and watchdog restore fields; bit 6 by command only
// [RULE_08] offset 03h resets to 12h, all bits writable
// [RULE_09] bits 7:4 precharge, 20 mA offset, 20 mA steps, default 40 mA
// [RULE_10] precharge codes above 1100 clamp to 260 mA
// [RULE_11] bits 3:0 termination current, default 60 mA, clamp at 260 mA
// [RULE_12] offset 04h resets to 40h, all bits writable
// [RULE_13] bits 7:3 voltage target, table up to 4.150 V, default 4.200 V
// [RULE_14] codes 01001 to 11111 run 4.300 V to 4.520 V in 10 mV steps
// [RULE_15] bits 2:1 top-off timer: off, 15, 30, 45 minutes
// [RULE_16] bit 0 recharge drop: 120 mV or 210 mV
// [RULE_17] charge only with enable pin low, charge allow set, current nonzero
// [RULE_18] host kicks watchdog by writing 1; device clears the bit after restart
`include "charger_map.vh"
`timescale 1ns/10ps
`default_nettype none

module charge_setpoint_registers #(
   parameter [31:0] WDOG_CYCLES = `WDOG_CYCLES,
   parameter [6:0]  DEV_ADDR    = 7'h2A  // arbitrary value
) (
   input  wire        clk_sys_in,                  // 40 MHz system clock
   input  wire        reset_in,                    // sync reset, active high
   input  wire        scl_in,                      // serial clock pin
   input  wire        sda_in,                      // serial data pin level
   output wire        sda_out,                     // data drive level
   output wire        sda_oe_out,                  // data pulled low
   input  wire        charge_enable_n_in,          // charge enable pin
   input  wire        reg_reset_cmd_in,            // register reset pulse
   input  wire [4:0]  input_current_cap_in,        // input limit code
   output reg  [10:0] fast_charge_current_out,     // mA
   output reg  [8:0]  precharge_current_out,       // mA
   output reg  [8:0]  termination_current_out,     // mA
   output reg  [12:0] charge_voltage_target_out,   // mV
   output reg  [5:0]  topoff_duration_out,         // minutes, 0 off
   output reg  [7:0]  recharge_drop_out,           // mV below target
   output reg         input_switch_full_drive_out, // full switch drive
   output reg         charge_enable_out,           // charger may run
   output reg         watchdog_expired_out         // one-cycle pulse
);

   reg  [7:0]  charge_current_limit_q;
   reg  [7:0]  precharge_termination_limit_q;
   reg  [7:0]  battery_voltage_limit_q;
   reg         charge_allow_q;
   reg         watchdog_kick_q;
   reg  [31:0] wdog_cnt_q;
   reg  [1:0]  ce_sync_q;
   reg  [7:0]  rdata;
   reg  [10:0] fast_ma;
   reg  [12:0] volt_mv;
   wire        bus_wr;
   wire [7:0]  bus_ptr;
   wire [7:0]  bus_wdata;
   wire [8:0]  pre_ma;
   wire [8:0]  term_ma;
   wire [5:0]  fast_code;
   wire [4:0]  volt_code;
   wire [1:0]  topoff_code;
   wire        wdog_fire;
   wire [12:0] volt_steps;
   wire [7:0]  rst_chg;

   assign sda_out     = 1'b0;
   assign fast_code   = charge_current_limit_q[`FLD_FAST_HI:0];
   assign volt_code   =
      battery_voltage_limit_q[`FLD_VOLT_HI:`FLD_VOLT_LO];
   assign topoff_code =
      battery_voltage_limit_q[`FLD_TOPOFF_HI:`FLD_TOPOFF_LO];
   assign wdog_fire   = (wdog_cnt_q == WDOG_CYCLES - 32'h1);
   assign volt_steps  = {8'h00, volt_code - `VOLT_LIN_FIRST};
   assign rst_chg     = `RST_CHG_CURRENT;

   i2c_target #(
      .DEV_ADDR (DEV_ADDR)
   ) u_i2c (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .sda_oe_out (sda_oe_out),
      .wr_out     (bus_wr),
      .ptr_out    (bus_ptr),
      .wdata_out  (bus_wdata),
      .rdata_in   (rdata)
   );

   code_clamp #(
      .MAX_CODE (`STEP_CODE_MAX)
   ) u_pre_clamp (
      .code_in (precharge_termination_limit_q[`FLD_PRE_HI:`FLD_PRE_LO]),
      .ma_out  (pre_ma)                                    // RULE_09
   );                                                      // RULE_10

   code_clamp #(
      .MAX_CODE (`STEP_CODE_MAX)
   ) u_term_clamp (
      .code_in (precharge_termination_limit_q[`FLD_TERM_HI:0]),
      .ma_out  (term_ma)                                   // RULE_11
   );

   // read mux; unmapped offsets read zero
   always @* begin
      if (bus_ptr == `OFS_CHG_CTRL) begin
         rdata = 8'h00;
         rdata[`BIT_WDOG_KICK]    = watchdog_kick_q;
         rdata[`BIT_CHARGE_ALLOW] = charge_allow_q;
      end else if (bus_ptr == `OFS_CHG_CURRENT) begin
         rdata = charge_current_limit_q;
      end else if (bus_ptr == `OFS_PRE_TERM) begin
         rdata = precharge_termination_limit_q;
      end else if (bus_ptr == `OFS_BAT_VOLTAGE) begin
         rdata = battery_voltage_limit_q;
      end else begin
         rdata = 8'h00;
      end
   end

   always @* begin
      if (fast_code <= `FAST_LINEAR_MAX) begin
         fast_ma = {1'b0, fast_code, 4'h0} +
                   {3'h0, fast_code, 2'h0};                      // RULE_02
      end else if (fast_code == 6'h3C) begin
         fast_ma = `FAST_MA_3C;                                  // RULE_03
      end else if (fast_code == 6'h3D) begin
         fast_ma = `FAST_MA_3D;                                  // RULE_03
      end else if (fast_code == 6'h3E) begin
         fast_ma = `FAST_MA_3E;                                  // RULE_04
      end else begin
         fast_ma = `FAST_MA_3F;                                  // RULE_04
      end
   end

   always @* begin
      case (volt_code)                                           // RULE_13
         5'h00:   volt_mv = 13'h0DB0;
         5'h01:   volt_mv = 13'h0E10;
         5'h02:   volt_mv = 13'h0E70;
         5'h03:   volt_mv = 13'h0ED8;
         5'h04:   volt_mv = 13'h0F40;
         5'h05:   volt_mv = 13'h0FA0;
         5'h06:   volt_mv = 13'h1004;
         5'h07:   volt_mv = 13'h1036;
         5'h08:   volt_mv = 13'h1068;
         default: volt_mv = `VOLT_LIN_BASE + {volt_steps[9:0], 3'h0}
                            + {volt_steps[11:0], 1'b0};         // RULE_14
      endcase
   end

   // register file: reset command beats watchdog, which beats a host write
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         charge_current_limit_q        <= `RST_CHG_CURRENT;   // RULE_01
         precharge_termination_limit_q <= `RST_PRE_TERM;      // RULE_08
         battery_voltage_limit_q       <= `RST_BAT_VOLTAGE;   // RULE_12
         charge_allow_q                <= `RST_CHARGE_ALLOW;
         watchdog_kick_q               <= 1'b0;
      end else if (reg_reset_cmd_in || wdog_fire) begin
         // reserved bit keeps its value; only power-on sets it
         if (reg_reset_cmd_in) begin
            charge_current_limit_q[`BIT_SWITCH_FULL] <=
               rst_chg[`BIT_SWITCH_FULL];                     // RULE_07
         end
         charge_current_limit_q[`FLD_FAST_HI:0] <=
            rst_chg[`FLD_FAST_HI:0];                          // RULE_07
         precharge_termination_limit_q <= `RST_PRE_TERM;      // RULE_07
         battery_voltage_limit_q       <= `RST_BAT_VOLTAGE;   // RULE_07
         charge_allow_q                <= `RST_CHARGE_ALLOW;
         watchdog_kick_q               <= 1'b0;
      end else begin
         // a kick lasts one cycle unless rewritten
         watchdog_kick_q <= 1'b0;                             // RULE_18
         if (bus_wr) begin
            if (bus_ptr == `OFS_CHG_CTRL) begin
               charge_allow_q  <= bus_wdata[`BIT_CHARGE_ALLOW];
               watchdog_kick_q <= bus_wdata[`BIT_WDOG_KICK];  // RULE_18
            end else if (bus_ptr == `OFS_CHG_CURRENT) begin
               charge_current_limit_q <= bus_wdata;           // RULE_01
            end else if (bus_ptr == `OFS_PRE_TERM) begin
               precharge_termination_limit_q <= bus_wdata;    // RULE_08
            end else if (bus_ptr == `OFS_BAT_VOLTAGE) begin
               battery_voltage_limit_q <= bus_wdata;          // RULE_12
            end
         end
      end
   end

   // count restarts on kick, reset command or expiry
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         wdog_cnt_q           <= 32'h0;
         watchdog_expired_out <= 1'b0;
      end else begin
         watchdog_expired_out <= wdog_fire;
         if (watchdog_kick_q || reg_reset_cmd_in || wdog_fire) begin
            wdog_cnt_q <= 32'h0;                              // RULE_18
         end else begin
            wdog_cnt_q <= wdog_cnt_q + 32'h1;
         end
      end
   end

   // the enable pin is asynchronous to this clock
   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         ce_sync_q <= 2'h3;
      end else begin
         ce_sync_q <= {ce_sync_q[0], charge_enable_n_in};
      end
   end

   always @(posedge clk_sys_in) begin
      if (reset_in) begin
         fast_charge_current_out     <= 11'h000;
         precharge_current_out       <= 9'h000;
         termination_current_out     <= 9'h000;
         charge_voltage_target_out   <= 13'h0000;
         topoff_duration_out         <= 6'h00;
         recharge_drop_out           <= 8'h00;
         input_switch_full_drive_out <= 1'b0;
         charge_enable_out           <= 1'b0;
      end else begin
         fast_charge_current_out   <= fast_ma;
         precharge_current_out     <= pre_ma;
         termination_current_out   <= term_ma;
         charge_voltage_target_out <= volt_mv;
         topoff_duration_out       <=
            (topoff_code == 2'h3) ? 6'h2D :
            (topoff_code == 2'h2) ? 6'h1E :
            (topoff_code == 2'h1) ? `TOPOFF_STEP_MIN : 6'h00; // RULE_15
         recharge_drop_out <=
            battery_voltage_limit_q[`BIT_RECHARGE] ?
            `RECHG_HIGH_MV : `RECHG_LOW_MV;                   // RULE_16
         input_switch_full_drive_out <=
            charge_current_limit_q[`BIT_SWITCH_FULL] |
            (input_current_cap_in >= `SWITCH_FULL_CAP);       // RULE_06
         charge_enable_out <= ~ce_sync_q[1] & charge_allow_q &
                              (fast_code != 6'h00);           // RULE_17 RULE_05
      end
   end

endmodule // charge_setpoint_registers

`default_nettype wire

// >>> charge_setpoint_checker_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module charge_setpoint_checker (
   input wire logic        clk_sys_in, // clock
   input wire logic        reset_in, // sync reset
   input wire logic        reg_reset_cmd_in, // reset command
   input wire logic        charge_enable_n_in, // enable pin
   input wire logic [4:0]  input_current_cap_in, // input limit
   input wire logic [10:0] fast_charge_current_out, // mA
   input wire logic [8:0]  precharge_current_out, // mA
   input wire logic [8:0]  termination_current_out, // mA
   input wire logic [12:0] charge_voltage_target_out, // mV
   input wire logic [5:0]  topoff_duration_out, // minutes
   input wire logic [7:0]  recharge_drop_out, // mV
   input wire logic        input_switch_full_drive_out, // full drive
   input wire logic        charge_enable_out, // may charge
   input wire logic        watchdog_expired_out // expiry pulse
);
   logic [1:0] up_q;
   wire        live = (up_q == 2'h3);
   // range and switch checks start three edges after reset
   always_ff @(posedge clk_sys_in)
      up_q <= reset_in ? 2'h0 : up_q + {1'b0, !live};
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   sequence defaults_s;
      fast_charge_current_out == 11'h154 && precharge_current_out == 9'h028
      && termination_current_out == 9'h03C && recharge_drop_out == 8'h78
      && charge_voltage_target_out == 13'h1068 && topoff_duration_out == 6'h00;
   endsequence
   sequence expiry_s;
      watchdog_expired_out ##1 !watchdog_expired_out;
   endsequence
   wd_pulse_a: assert property (watchdog_expired_out |-> expiry_s)
      else $error("long expiry pulse");
   wd_defaults_a: assert property (expiry_s |-> defaults_s)
      else $error("no defaults after expiry");
   cmd_defaults_a: assert property (
      reg_reset_cmd_in |-> ##[1:3] defaults_s)
      else $error("no defaults after command");
   switch_full_a: assert property (
      (live && input_current_cap_in >= 5'h06) [*3]
      |-> input_switch_full_drive_out)
      else $error("switch not full");
   zero_current_a: assert property (
      (fast_charge_current_out == 11'h000) [*2] |-> !charge_enable_out)
      else $error("charging at zero current");
   pin_off_a: assert property (
      charge_enable_n_in [*5] |-> !charge_enable_out)
      else $error("charging with pin high");
   pre_range_a: assert property (live |->
      precharge_current_out inside {[9'h014:9'h104]}
      && precharge_current_out % 9'h014 == 9'h000)
      else $error("precharge off grid");
   term_range_a: assert property (live |->
      termination_current_out inside {[9'h014:9'h104]}
      && termination_current_out % 9'h014 == 9'h000)
      else $error("termination off grid");
   volt_range_a: assert property (live |->
      charge_voltage_target_out inside {[13'h0DB0:13'h11A8]})
      else $error("voltage out of range");
   topoff_set_a: assert property (live |->
      topoff_duration_out inside {6'h00, 6'h0F, 6'h1E, 6'h2D})
      else $error("bad top-off time");
   drop_set_a: assert property (live |->
      recharge_drop_out inside {8'h78, 8'hD2})
      else $error("bad recharge drop");
endmodule // charge_setpoint_checker
bind charge_setpoint_registers charge_setpoint_checker
   i_charge_setpoint_checker (
   .clk_sys_in(clk_sys_in), .reset_in(reset_in),
   .reg_reset_cmd_in(reg_reset_cmd_in),
   .charge_enable_n_in(charge_enable_n_in),
   .input_current_cap_in(input_current_cap_in),
   .fast_charge_current_out(fast_charge_current_out),
   .precharge_current_out(precharge_current_out),
   .termination_current_out(termination_current_out),
   .charge_voltage_target_out(charge_voltage_target_out),
   .topoff_duration_out(topoff_duration_out),
   .recharge_drop_out(recharge_drop_out),
   .input_switch_full_drive_out(input_switch_full_drive_out),
   .charge_enable_out(charge_enable_out),
   .watchdog_expired_out(watchdog_expired_out));
`default_nettype wire

// >>> i2c_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
) (
   input  wire logic clk_in,      // system clock
   input  wire logic sda_in,      // resolved data wire
   output var logic  scl_out,     // serial clock
   output var logic  sda_low_out  // pull data low
);
   logic [7:0] rx;
   logic       nk;
   initial {scl_out, sda_low_out} = 2'h2;
   // six clocks a phase: four-clock minimum plus sync delay
   task automatic put(input logic s, input logic d);
      scl_out = s;
      sda_low_out = d;
      repeat (6) @(posedge clk_in);
      #2;
   endtask
   task automatic start();
      put(scl_out, 1'b0);
      put(1'b1, 1'b0);
      put(1'b1, 1'b1);
      put(1'b0, 1'b1);
   endtask
   task automatic stop();
      put(scl_out, 1'b1);
      put(1'b1, 1'b1);
      put(1'b1, 1'b0);
   endtask
   task automatic bit_io(input logic b, output logic r);
      put(scl_out, ~b);
      put(1'b1, ~b);
      r = sda_in;
      put(1'b0, ~b);
   endtask
   // ninth bit released; a read ends unacked
   task automatic xbyte(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(1'b1, nk);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      start();
      xbyte({DEV_ADDR, 1'b0});
      xbyte(p);
      xbyte(d);
      stop();
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      start();
      xbyte({DEV_ADDR, 1'b0});
      xbyte(p);
      start();
      xbyte({DEV_ADDR, 1'b1});
      xbyte(8'hFF);
      d = rx;
      stop();
   endtask
endmodule // i2c_host_model
`default_nettype wire

// >>> charge_setpoint_registers_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      n_compared++; \
      if ((got) !== (ex)) begin \
         num_errors++; \
         $display("mismatch %s exp %0d got %0d", nm, ex, got); \
      end \
   end
module charge_setpoint_registers_tb;
   localparam int WD = 8000;
   int          vlut[8] = '{3504, 3600, 3696, 3800, 3904, 4000, 4100, 4150};
   int          num_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   logic        clk_sys_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        chg_n = 1'b0;
   logic        rcmd = 1'b0;
   logic [4:0]  cap = 5'h00;
   wire         scl, host_low, sda_oe, full, en, wdx;
   wire         sda = ~(host_low | sda_oe);
   wire  [10:0] fast;
   wire  [8:0]  pre, term;
   wire  [12:0] volt;
   wire  [5:0]  topoff;
   wire  [7:0]  drop;
   charge_setpoint_registers #(.WDOG_CYCLES(WD))
   i_charge_setpoint_registers (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .scl_in(scl),
      .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
      .charge_enable_n_in(chg_n), .reg_reset_cmd_in(rcmd),
      .input_current_cap_in(cap), .fast_charge_current_out(fast),
      .precharge_current_out(pre), .termination_current_out(term),
      .charge_voltage_target_out(volt), .topoff_duration_out(topoff),
      .recharge_drop_out(drop), .input_switch_full_drive_out(full),
      .charge_enable_out(en), .watchdog_expired_out(wdx));
   i2c_host_model i_i2c_host_model (.clk_in(clk_sys_in), .sda_in(sda),
      .scl_out(scl), .sda_low_out(host_low));
   function automatic int fast_ma(int c);
      return (c <= 59) ? c * 20 : 1290 + (c - 60) * 70;
   endfunction
   function automatic int step_ma(int c);
      return ((c > 12) ? 13 : c + 1) * 20;
   endfunction
   function automatic int volt_mv(int c);
      return (c < 8) ? vlut[c] : (c == 8) ? 4200 : 4300 + (c - 9) * 10;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys_in);
      #2;
   endtask
   task automatic wr(logic [7:0] p, logic [7:0] d);
      i_i2c_host_model.wr(p, d);
   endtask
   task automatic rd_chk(logic [7:0] p, logic [7:0] ex);
      logic [7:0] d;
      i_i2c_host_model.rd(p, d);
      `CHK("readback", ex, d)
   endtask
   task automatic kick();
      wr(8'h01, 8'h50);
   endtask
   task automatic chk_dflt();
      `CHK("fast", 340, fast)
      `CHK("pre", 40, pre)
      `CHK("term", 60, term)
      `CHK("volt", 4200, volt)
      `CHK("topoff", 0, topoff)
      `CHK("drop", 120, drop)
   endtask
   task automatic t_reset();
      rd_chk(8'h02, 8'h91);
      rd_chk(8'h03, 8'h12);
      rd_chk(8'h04, 8'h40);
      chk_dflt();
      `CHK("enable", 1'b1, en)
      kick();
      rd_chk(8'h01, 8'h10);
   endtask
   task automatic t_fast();
      logic [5:0] c[7] = '{6'h00, 6'h11, 6'h3B, 6'h3C, 6'h3D, 6'h3E, 6'h3F};
      kick();
      foreach (c[i]) begin
         wr(8'h02, {2'h2, c[i]});
         `CHK("fast", fast_ma(c[i]), fast)
         `CHK("enable", c[i] != 6'h00, en)
      end
      rd_chk(8'h02, 8'hBF);
      wr(8'h02, 8'h11);
      rd_chk(8'h02, 8'h11);
   endtask
   task automatic t_fields();
      logic [7:0] q[4] = '{8'h00, 8'hCC, 8'hDF, 8'hFD};
      logic [7:0] c[6] = '{8'h00, 8'h39, 8'h42, 8'h4D, 8'h70, 8'hFF};
      kick();
      foreach (q[i]) begin
         wr(8'h03, q[i]);
         `CHK("pre", step_ma(q[i][7:4]), pre)
         `CHK("term", step_ma(q[i][3:0]), term)
      end
      rd_chk(8'h03, 8'hFD);
      foreach (c[i]) begin
         wr(8'h04, c[i]);
         `CHK("volt", volt_mv(c[i][7:3]), volt)
         `CHK("topoff", c[i][2:1] * 15, topoff)
         `CHK("drop", c[i][0] ? 210 : 120, drop)
      end
      rd_chk(8'h04, 8'hFF);
   endtask
   task automatic t_switch();
      kick();
      cap = 5'h05;
      tick(3);
      `CHK("full", 1'b0, full)
      cap = 5'h06;
      tick(3);
      `CHK("full", 1'b1, full)
      cap = 5'h00;
      wr(8'h02, 8'h51);
      `CHK("full", 1'b1, full)
      chg_n = 1'b1;
      tick(6);
      `CHK("enable", 1'b0, en)
      chg_n = 1'b0;
      wr(8'h01, 8'h40);
      `CHK("enable", 1'b0, en)
      wr(8'h01, 8'h50);
      `CHK("enable", 1'b1, en)
   endtask
   task automatic t_cmd();
      kick();
      wr(8'h02, 8'hFF);
      wr(8'h03, 8'hFF);
      wr(8'h04, 8'hFF);
      rcmd = 1'b1;
      tick(1);
      rcmd = 1'b0;
      tick(4);
      chk_dflt();
      `CHK("full", 1'b0, full)
      rd_chk(8'h02, 8'h91);
   endtask
   task automatic t_wd();
      int n = 0;
      wr(8'h02, 8'h7F);
      wr(8'h04, 8'hFF);
      while (wdx !== 1'b1 && n < 2 * WD) begin
         tick(1);
         n++;
      end
      `CHK("expiry", 1'b1, wdx)
      tick(3);
      chk_dflt();
      `CHK("full", 1'b1, full)
      rd_chk(8'h02, 8'h51);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always #12.5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      tick(16);
      reset_in = 1'b0;
      tick(2);
      t_reset();
      t_fast();
      t_fields();
      t_switch();
      t_cmd();
      t_wd();
      tally_and_finish();
   end
endmodule // charge_setpoint_registers_tb
`default_nettype wire
